// ---- bench/csi_pkt_source.sv ----
// Serializer-side packet source that feeds the receive port bench
`default_nettype none
module csi_pkt_source (
  input wire logic i_clk, // Bench clock
  input wire logic i_go, // Send one packet
  input wire logic i_port, // Port of the packet
  input wire logic [3:0] i_err, // Faults: length, checksum, multi, single
  input wire logic [31:0] i_raw, // Header word of the packet
  output logic [1:0] o_pkt_end, // Packet done pulse
  output logic [1:0] o_len, // Length fault level
  output logic [1:0] o_ck, // Checksum fault level
  output logic [1:0] o_multi, // Multi-bit header fault level
  output logic [1:0] o_single, // Single-bit header fault level
  output logic [63:0] o_hdr, // Raw header, both ports
  output logic [63:0] o_fix // Corrected header, both ports
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] err_q = 4'h0;
  logic [31:0] raw_q = 32'h0;
  logic [3:0] lvl;
  initial o_pkt_end = 2'h0;
  // Levels only count at packet end, so between packets they show the inverse
  always @(posedge i_clk)
  begin
    o_pkt_end <= i_go ? 2'h1 << i_port : 2'h0;
    err_q <= i_go ? i_err : err_q;
    raw_q <= i_go ? i_raw : ~raw_q;
  end
  assign lvl = (o_pkt_end != 2'h0) ? err_q : ~err_q;
  assign o_len = {2{lvl[3]}};
  assign o_ck = {2{lvl[2]}};
  assign o_multi = {2{lvl[1]}};
  assign o_single = {2{lvl[0]}};
  assign o_hdr = {2{raw_q}};
  assign o_fix = {2{raw_q ^ 32'h10}};
endmodule
`default_nettype wire

// ---- bench/rx_port_csi_error_and_forwarding_asserts.sv ----
// Port-level assertions for the receive port status block
`default_nettype none
module rx_port_checker #(
  parameter int ports = 2,
  parameter int sel_w = 1
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst_b, // Reset, active low
  input wire logic i_reg_wr, // Write strobe
  input wire logic i_reg_rd, // Read strobe
  input wire logic [7:0] i_reg_addr, // Offset
  input wire logic [7:0] o_reg_rdata, // Read data
  input wire logic [ports-1:0] i_pkt_end, // Packet done
  input wire logic [ports-1:0] i_ecc_multi, // Bad header
  input wire logic [ports-1:0] i_ecc_single, // Fixable header
  input wire logic [ports*32-1:0] i_hdr, // Raw header
  input wire logic [ports*32-1:0] i_hdr_fixed, // Fixed header
  input wire logic [ports*32-1:0] o_hdr, // Forwarded header
  input wire logic [ports*10-1:0] i_pixel, // Pixel in
  input wire logic [ports*10-1:0] o_pixel, // Pixel out
  input wire logic [ports-1:0] i_lock, // Receiver lock
  input wire logic [ports-1:0] o_forward, // Forwarding
  input wire logic [ports-1:0] o_pass // Pass
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic [2:0] up_q;
  // Release runs through two flops and an output register, so wait first
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b) up_q <= 3'h0;
    else if (!up_q[2]) up_q <= up_q + 3'h1;
  end
  wire logic live = up_q[2];
  chk_hdr_fixed: assert property (
    live |-> o_hdr[31:0] == ($past(i_ecc_single[0] && !i_ecc_multi[0]) ?
      $past(i_hdr_fixed[31:0]) : $past(i_hdr[31:0]))) else $error("header not fixed");
  chk_hdr_raw: assert property (
    live && i_ecc_multi[0] |=> o_hdr[31:0] == $past(i_hdr[31:0])) else $error("header altered");
  chk_pix_pack: assert property (
    live |-> o_pixel[9:0] == $past(i_pixel[9:0])
      || o_pixel[9:0] == {2'h0, $past(i_pixel[9:2])}
      || o_pixel[9:0] == {2'h0, $past(i_pixel[7:0])}) else $error("pixel packing wrong");
  chk_pass_lock: assert property (
    !i_lock[0] |-> !o_pass[0]) else $error("pass without lock");
  chk_fwd_pass: assert property (
    o_forward[0] |-> o_pass[0]) else $error("forward without pass");
  chk_flags_clear: assert property (
    (live && i_reg_rd && !i_reg_wr && i_reg_addr == 8'h7a && i_pkt_end == '0) ##1
    (i_reg_rd && i_reg_addr == 8'h7a) |=> o_reg_rdata[3:0] == 4'h0) else $error("flags kept");
  chk_tally_clear: assert property (
    (live && i_reg_rd && !i_reg_wr && i_reg_addr == 8'h7b && i_pkt_end == '0) ##1
    (i_reg_rd && i_reg_addr == 8'h7b) |=> o_reg_rdata == 8'h00) else $error("tally kept");
  chk_unmapped_zero: assert property (
    live && i_reg_rd && i_reg_addr == 8'h55 |=> o_reg_rdata == 8'h00) else $error("unmapped read");
  chk_flags_upper: assert property (
    live && i_reg_rd && i_reg_addr == 8'h7a |=> o_reg_rdata[7:4] == 4'h0) else $error("flag bits");
endmodule
bind rx_port_csi_error_and_forwarding rx_port_checker #(.ports(ports), .sel_w(sel_w))
  u_rx_port_checker (.i_clk, .i_rst_b, .i_reg_wr, .i_reg_rd, .i_reg_addr, .o_reg_rdata,
  .i_pkt_end, .i_ecc_multi, .i_ecc_single, .i_hdr, .i_hdr_fixed, .o_hdr, .i_pixel,
  .o_pixel, .i_lock, .o_forward, .o_pass);
`default_nettype wire

// ---- bench/rx_port_csi_error_and_forwarding_tb_top.sv ----
// Self-checking bench for the receive port status and forwarding block
`default_nettype none
module rx_port_csi_error_and_forwarding_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst_b, i_reg_wr, i_reg_rd, i_go, i_port;
  logic [7:0] i_reg_addr, i_reg_wdata;
  logic [3:0] i_err;
  logic [31:0] i_raw;
  logic [1:0] i_lock, i_frame_end, i_parity_fault, i_line_size_change, i_frame_size_change;
  logic [1:0] i_line_valid, i_frame_valid;
  logic [19:0] i_pixel;
  wire logic [1:0] i_pkt_end, i_length_fault, i_checksum_fault, i_ecc_multi, i_ecc_single;
  wire logic [1:0] o_line_active, o_frame_active, o_forward, o_pass;
  wire logic [63:0] i_hdr, i_hdr_fixed, o_hdr;
  wire logic [7:0] o_reg_rdata;
  wire logic [19:0] o_pixel;
  int err_total, n_checks, sel, c;
  int flg [2], cnt [2], cfg [2];
  rx_port_csi_error_and_forwarding #(.ports(2), .sel_w(1)) u_rx_port_csi_error_and_forwarding (
    .i_clk, .i_rst_b, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .i_pkt_end, .i_length_fault, .i_checksum_fault, .i_ecc_multi, .i_ecc_single, .i_hdr,
    .i_hdr_fixed, .o_hdr, .i_lock, .i_frame_end, .i_parity_fault, .i_line_size_change,
    .i_frame_size_change, .i_pixel, .o_pixel, .i_line_valid, .i_frame_valid, .o_line_active,
    .o_frame_active, .o_forward, .o_pass);
  csi_pkt_source u_csi_pkt_source (.i_clk, .i_go, .i_port, .i_err, .i_raw,
    .o_pkt_end(i_pkt_end), .o_len(i_length_fault), .o_ck(i_checksum_fault),
    .o_multi(i_ecc_multi), .o_single(i_ecc_single), .o_hdr(i_hdr), .o_fix(i_hdr_fixed));
  // Free-running 100 MHz clock
  always #5 i_clk = ~i_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Register write; the model follows port select and config
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(posedge i_clk);
    #1 i_reg_wr = 1'b0;
    if (a == 8'h4c) sel = d[0];
    if (a == 8'h7c) cfg[sel] = d;
    // Idle edge, so a following call never re-raises the strobe in this step
    @(posedge i_clk);
    #1;
  endtask
  // Register read; k keeps the strobe up for a back-to-back read
  task automatic rd(input logic [7:0] a, input int e, input bit k);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(posedge i_clk);
    #1 if (!k) i_reg_rd = 1'b0;
    chk("reg_rdata", o_reg_rdata, e);
    if (!k)
    begin
      @(posedge i_clk);
      #1;
    end
  endtask
  // One packet; a multi-bit fault hides the single-bit one
  task automatic pkt(input bit p, input logic [3:0] e);
    i_go = 1'b1;
    i_port = p;
    i_err = e;
    i_raw = $urandom;
    @(posedge i_clk);
    #1 i_go = 1'b0;
    @(posedge i_clk);
    #1 flg[p] |= e[1] ? e & 4'he : e;
    if (e != 4'h0 && cnt[p] < 255) cnt[p]++;
    chk("hdr", o_hdr[p*32 +: 32], (e[0] && !e[1]) ? i_raw ^ 32'h10 : i_raw);
  endtask
  task automatic fe();
    i_frame_end[0] = 1'b1;
    @(posedge i_clk);
    #1 i_frame_end[0] = 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  function automatic int pk(int m, logic [9:0] x);
    if (m[7:6] == rx_port_pkg::raw10_upper8) return x[9:2];
    if (m[7:6] == rx_port_pkg::raw10_lower8) return x[7:0];
    return x;
  endfunction
  // Long enough for every sequence below with a wide margin
  initial
  begin
    #200000 err_total++;
    end_sim();
  end
  initial
  begin
    void'($urandom(76129));
    {i_clk, i_rst_b, i_reg_wr, i_reg_rd, i_go, i_port, i_err, i_raw} = '0;
    {i_reg_addr, i_reg_wdata, i_frame_end, i_parity_fault, i_pixel} = '0;
    {i_line_size_change, i_frame_size_change, i_line_valid, i_frame_valid} = '0;
    i_lock = 2'h3;
    repeat (4) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    repeat (4) @(posedge i_clk);
    #1 wr(8'h55, 8'ha5);
    rd(8'h55, 0, 0);
    for (int p = 0; p < 2; p++)
    begin
      wr(8'h4c, 8'(p));
      wr(8'h7a, 8'hff);
      for (int a = 8'h7a; a < 8'h7e; a++) rd(8'(a), 0, 0);
    end
    repeat (24)
    begin
      wr(8'h4c, 8'($urandom % 2));
      c = $urandom & 32'hc3;
      wr(8'h7c, 8'(c));
      if (c[7]) wr(8'h70, 8'h2a);
      rd(8'h7c, c, 0);
      i_pixel = 20'($urandom);
      i_line_valid = 2'($urandom);
      i_frame_valid = 2'($urandom);
      @(posedge i_clk);
      #1;
      for (int q = 0; q < 2; q++)
      begin
        chk("pixel", o_pixel[q*10+:10], pk(cfg[q], i_pixel[q*10+:10]));
        chk("line", o_line_active[q], i_line_valid[q] ^ cfg[q][1]);
        chk("frame", o_frame_active[q], i_frame_valid[q] ^ cfg[q][0]);
      end
    end
    repeat (60)
    begin
      pkt(1'($urandom), 4'($urandom));
      if ($urandom % 4 == 0)
      begin
        wr(8'h4c, 8'($urandom % 2));
        rd(8'h7a, flg[sel], 1);
        flg[sel] = 0;
        rd(8'h7a, 0, 0);
        rd(8'h7b, cnt[sel], 1);
        cnt[sel] = 0;
        rd(8'h7b, 0, 0);
      end
    end
    wr(8'h4c, 8'h1);
    repeat (260) pkt(1'b1, 4'h4);
    rd(8'h7b, cnt[1], 0);
    for (int k = 0; k < 3; k++)
      for (int en = 0; en < 2; en++)
      begin
        wr(8'h4c, 8'h0);
        wr(8'h7d, 8'h0);
        wr(8'h7c, 8'(en << (5 - k)));
        {i_parity_fault[0], i_line_size_change[0], i_frame_size_change[0]} = 3'h4 >> k;
        #1 chk("forward", o_forward[0], !en);
        @(posedge i_clk);
        #1 {i_parity_fault[0], i_line_size_change[0], i_frame_size_change[0]} = 3'h0;
        chk("forward", o_forward[0], !en);
        fe();
        chk("forward", o_forward[0], 1);
      end
    wr(8'h7d, 8'h2);
    i_frame_size_change[0] = 1'b1;
    @(posedge i_clk);
    #1 i_frame_size_change[0] = 1'b0;
    chk("pass", o_pass[0], 0);
    repeat (2) fe();
    chk("pass", o_pass[0], 1);
    fe();
    chk("forward", o_forward[0], 1);
    wr(8'h7d, 8'h0);
    i_lock = 2'h2;
    #1 chk("pass", o_pass[0], 0);
    @(posedge i_clk);
    #1 i_lock = 2'h3;
    #1 chk("pass", o_pass[0], 1);
    end_sim();
  end
endmodule
`default_nettype wire

// ---- hw/port_bank_mem.sv ----
// Per-port configuration store with registered read data
`default_nettype none
module port_bank_mem #(
  parameter int ports = 2,
  parameter int sel_w = 1
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rst_n, // Synchronised reset, active low
  input wire logic i_we, // Write strobe
  input wire logic [sel_w-1:0] i_wsel, // Port written
  input wire logic [7:0] i_wdata, // Write data
  input wire logic [sel_w-1:0] i_rsel, // Port read
  output logic [7:0] o_rdata, // Registered read data
  output logic [ports*8-1:0] o_all // Every bank, for the datapaths
);
  logic [7:0] mem_q [ports];
  // ------------------------------------------------------------
  // Storage, one byte per port
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ports; g++)
    begin : g_bank
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          mem_q[g] <= rx_port_pkg::config_reset;
        else if (i_we && i_wsel == sel_w'(g))
          mem_q[g] <= i_wdata;
      end
      assign o_all[g*8 +: 8] = mem_q[g];
    end
  endgenerate
  // Read port
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else
      o_rdata <= mem_q[i_rsel];
  end
endmodule
`default_nettype wire

// ---- hw/rx_port_csi_error_and_forwarding.sv ----
// Per-port CSI error status, error tally and video forwarding control
// Notes on behaviour
// - Length mismatch sets sticky length flag
// - Bad payload checksum sets sticky flag
// - Multi-bit header error flagged, left uncorrected
// - Single-bit header error corrected and flagged
// - Flags read one, clear when status read
// - Eight-bit errored packet count, cleared on read
// - Two-bit field selects Raw10 narrowing mode
// - Parity fault truncates frame when enabled
// - Line size change truncates frame when enabled
// - Frame size change truncates when enabled
// - After frame size truncation wait qualification count
// - Count zero passes as soon as locked
// - Line valid polarity bit selects active low
// - Frame valid polarity bit selects active low
// - Registers banked, chosen by port select
`default_nettype none
module rx_port_csi_error_and_forwarding #(
  parameter int ports = 2,
  parameter int sel_w = 1
) (
  input wire logic i_clk, // Core clock, 100 MHz
  input wire logic i_rst_b, // Asynchronous reset, active low
  input wire logic i_reg_wr, // Register write strobe
  input wire logic i_reg_rd, // Register read strobe
  input wire logic [7:0] i_reg_addr, // Register offset
  input wire logic [7:0] i_reg_wdata, // Write data
  output logic [7:0] o_reg_rdata, // Read data, valid cycle after read
  input wire logic [ports-1:0] i_pkt_end, // Packet finished, per port
  input wire logic [ports-1:0] i_length_fault, // Word count mismatch
  input wire logic [ports-1:0] i_checksum_fault, // Payload checksum bad
  input wire logic [ports-1:0] i_ecc_multi, // Uncorrectable header
  input wire logic [ports-1:0] i_ecc_single, // Correctable header
  input wire logic [ports*32-1:0] i_hdr, // Raw header, per port
  input wire logic [ports*32-1:0] i_hdr_fixed, // Header with one bit fixed
  output logic [ports*32-1:0] o_hdr, // Header forwarded
  input wire logic [ports-1:0] i_lock, // Receiver locked
  input wire logic [ports-1:0] i_frame_end, // Valid frame completed
  input wire logic [ports-1:0] i_parity_fault, // Link parity error
  input wire logic [ports-1:0] i_line_size_change, // Line length changed
  input wire logic [ports-1:0] i_frame_size_change, // Line count changed
  input wire logic [ports*10-1:0] i_pixel, // Raw10 pixel per port
  output logic [ports*10-1:0] o_pixel, // Packed pixel, 8-bit in low bits
  input wire logic [ports-1:0] i_line_valid, // Raw line valid pin
  input wire logic [ports-1:0] i_frame_valid, // Raw frame valid pin
  output logic [ports-1:0] o_line_active, // Line valid, active high
  output logic [ports-1:0] o_frame_active, // Frame valid, active high
  output logic [ports-1:0] o_forward, // Forwarding allowed
  output logic [ports-1:0] o_pass // Qualification achieved
);
  // Shared state; the per-port arrays are indexed by the receive port
  logic rst_meta_q;
  logic rst_n_q;
  logic [sel_w-1:0] port_sel_q;
  logic [1:0] threshold_q [ports];
  logic [7:0] flags_q [ports];
  logic [7:0] tally_q [ports];
  logic [ports*8-1:0] cfg_all;
  logic [7:0] cfg_rdata;
  logic [7:0] rd_addr_q;
  logic [7:0] direct_q;
  logic cfg_we;
  logic [ports-1:0] trunc_q;
  logic [2:0] good_q [ports];

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  // Two stages so release never lands near a clock edge
  // Assertion stays asynchronous; every other flop resets from rst_n_q
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  // Port select chooses which bank all banked offsets reach
  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      port_sel_q <= '0;
    else if (i_reg_wr && i_reg_addr == rx_port_pkg::port_select_addr)
      port_sel_q <= i_reg_wdata[sel_w-1:0];
  end

  // Writes to unmapped or read-only offsets fall through untouched
  assign cfg_we = i_reg_wr && i_reg_addr == rx_port_pkg::port_video_handling_config_addr;

  // Configuration lives in the bank store
  port_bank_mem #(
    .ports(ports),
    .sel_w(sel_w)
  ) u_cfg (
    .i_clk(i_clk),
    .i_rst_n(rst_n_q),
    .i_we(cfg_we),
    .i_wsel(port_sel_q),
    .i_wdata(i_reg_wdata),
    .i_rsel(port_sel_q),
    .o_rdata(cfg_rdata),
    .o_all(cfg_all)
  );

  // Direct read data captured alongside the store's registered read
  // Capture is side-effect free; the read clears live in the port logic
  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rd_addr_q <= 8'h00;
      direct_q <= 8'h00;
    end
    else
    begin
      rd_addr_q <= i_reg_addr;
      unique case (i_reg_addr)
        rx_port_pkg::port_select_addr: direct_q <= 8'(port_sel_q);
        rx_port_pkg::csi_receive_error_flags_addr: direct_q <= flags_q[port_sel_q];
        rx_port_pkg::csi_errored_packet_count_addr: direct_q <= tally_q[port_sel_q];
        rx_port_pkg::pass_threshold_addr: direct_q <= {6'h00, threshold_q[port_sel_q]};
        default: direct_q <= 8'h00; // Unmapped offsets read zero
      endcase
    end
  end

  // Output mux, so the answer follows a read by one cycle
  always_comb
  begin
    if (rd_addr_q == rx_port_pkg::port_video_handling_config_addr)
      o_reg_rdata = cfg_rdata;
    else
      o_reg_rdata = direct_q;
  end

  // ------------------------------------------------------------
  // Per-port status, tally and forwarding
  // ------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < ports; p++)
    begin : g_port
      logic sel_here;
      logic rd_flags;
      logic rd_tally;
      logic any_err;
      logic [7:0] cfg;
      logic [3:0] new_err;
      logic [1:0] narrow;
      logic trunc_evt;
      logic hdr_fix;
      assign sel_here = port_sel_q == sel_w'(p);
      assign cfg = cfg_all[p*8 +: 8];
      assign rd_flags = i_reg_rd && sel_here
        && i_reg_addr == rx_port_pkg::csi_receive_error_flags_addr;
      assign rd_tally = i_reg_rd && sel_here
        && i_reg_addr == rx_port_pkg::csi_errored_packet_count_addr;
      // ----------------------------------------------------------
      // Error capture and sticky status
      // ----------------------------------------------------------
      // Faults count only at packet end; the levels are ignored otherwise
      assign new_err[rx_port_pkg::length_fault_bit] = i_pkt_end[p] && i_length_fault[p];
      assign new_err[rx_port_pkg::payload_check_fail_bit] =
        i_pkt_end[p] && i_checksum_fault[p];
      assign new_err[rx_port_pkg::multibit_bit] = i_pkt_end[p] && i_ecc_multi[p];
      assign new_err[rx_port_pkg::singlebit_bit] =
        i_pkt_end[p] && i_ecc_single[p] && !i_ecc_multi[p];
      assign any_err = |new_err;

      // Sticky flags; a new error in the read cycle wins over the clear
      always_ff @(posedge i_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
          flags_q[p] <= rx_port_pkg::flags_reset;
        else if (rd_flags)
          flags_q[p] <= {4'h0, new_err};
        else
          flags_q[p] <= flags_q[p] | {4'h0, new_err};
      end

      // Errored packet tally, saturating; read restarts at zero or one
      // Saturating keeps an error burst visible as 0xff rather than wrapping
      always_ff @(posedge i_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
          tally_q[p] <= rx_port_pkg::count_reset;
        else if (rd_tally)
          tally_q[p] <= {7'h00, any_err};
        else if (any_err && tally_q[p] != rx_port_pkg::tally_max)
          tally_q[p] <= tally_q[p] + 8'h01;
      end

      // ----------------------------------------------------------
      // Header and pixel datapath
      // ----------------------------------------------------------
      // A multi-bit fault outranks the single one, so no miscorrection
      assign hdr_fix = i_ecc_single[p] && !i_ecc_multi[p];

      // Header forwarded raw when multi-bit, corrected when single-bit
      always_ff @(posedge i_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
          o_hdr[p*32 +: 32] <= 32'h0000_0000;
        else if (hdr_fix)
          o_hdr[p*32 +: 32] <= i_hdr_fixed[p*32 +: 32];
        else
          o_hdr[p*32 +: 32] <= i_hdr[p*32 +: 32];
      end

      // Raw10 narrowing; the reserved code behaves as normal
      assign narrow = cfg[rx_port_pkg::narrowing_hi:rx_port_pkg::narrowing_lo];
      always_ff @(posedge i_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
          o_pixel[p*10 +: 10] <= 10'h000;
        else
          unique case (narrow)
            rx_port_pkg::raw10_upper8: o_pixel[p*10 +: 10] <= {2'h0, i_pixel[p*10+2 +: 8]};
            rx_port_pkg::raw10_lower8: o_pixel[p*10 +: 10] <= {2'h0, i_pixel[p*10 +: 8]};
            default: o_pixel[p*10 +: 10] <= i_pixel[p*10 +: 10];
          endcase
      end

      // ----------------------------------------------------------
      // Raw sync polarity
      // ----------------------------------------------------------
      // Polarity correction of raw sync pins
      always_ff @(posedge i_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
        begin
          o_line_active[p] <= 1'b0;
          o_frame_active[p] <= 1'b0;
        end
        else
        begin
          o_line_active[p] <= i_line_valid[p] ^ cfg[rx_port_pkg::line_pol_bit];
          o_frame_active[p] <= i_frame_valid[p] ^ cfg[rx_port_pkg::frame_pol_bit];
        end
      end

      // ----------------------------------------------------------
      // Truncation and pass qualification
      // ----------------------------------------------------------
      // Any enabled discard cause cuts the frame short
      assign trunc_evt = (cfg[rx_port_pkg::parity_trunc_bit] && i_parity_fault[p])
        || (cfg[rx_port_pkg::line_size_trunc_bit] && i_line_size_change[p])
        || (cfg[rx_port_pkg::frame_size_trunc_bit] && i_frame_size_change[p]);

      // Truncation held to frame end, or until qualified after size change
      // Limitation: a cut frame stays cut even if its cause goes away
      always_ff @(posedge i_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
          trunc_q[p] <= 1'b0;
        else if (trunc_evt)
          trunc_q[p] <= 1'b1;
        else if (i_frame_end[p] && o_pass[p])
          trunc_q[p] <= 1'b0;
      end

      // Good frame count toward pass; an enabled frame size change or loss of lock restarts it
      // Three bits are enough, as the threshold field tops out at three
      always_ff @(posedge i_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
          good_q[p] <= 3'h0;
        else if (!i_lock[p] || (cfg[rx_port_pkg::frame_size_trunc_bit]
                 && i_frame_size_change[p]))
          good_q[p] <= 3'h0;
        else if (i_frame_end[p] && good_q[p] < {1'b0, threshold_q[p]})
          good_q[p] <= good_q[p] + 3'h1;
      end

      // Threshold zero passes on lock alone
      // Combinational, so pass drops in the same cycle that lock is lost
      assign o_pass[p] = i_lock[p] && good_q[p] >= {1'b0, threshold_q[p]};
      assign o_forward[p] = o_pass[p] && !trunc_q[p] && !trunc_evt;

      // ----------------------------------------------------------
      // Threshold register
      // ----------------------------------------------------------
      // Qualification threshold per port
      always_ff @(posedge i_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
          threshold_q[p] <= rx_port_pkg::threshold_reset;
        else if (i_reg_wr && sel_here && i_reg_addr == rx_port_pkg::pass_threshold_addr)
          threshold_q[p] <= i_reg_wdata[1:0];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- hw/rx_port_pkg.sv ----
// Constants shared by the receive port status and forwarding logic
`default_nettype none
package rx_port_pkg;
  // Register offsets; all but port select are banked per port
  localparam logic [7:0] port_select_addr = 8'h4c;
  localparam logic [7:0] csi_receive_error_flags_addr = 8'h7a;
  localparam logic [7:0] csi_errored_packet_count_addr = 8'h7b;
  localparam logic [7:0] port_video_handling_config_addr = 8'h7c;
  localparam logic [7:0] pass_threshold_addr = 8'h7d;
  // Field positions
  localparam int length_fault_bit = 3;
  localparam int payload_check_fail_bit = 2;
  localparam int multibit_bit = 1;
  localparam int singlebit_bit = 0;
  localparam int narrowing_hi = 7;
  localparam int narrowing_lo = 6;
  localparam int parity_trunc_bit = 5;
  localparam int line_size_trunc_bit = 4;
  localparam int frame_size_trunc_bit = 3;
  localparam int line_pol_bit = 1;
  localparam int frame_pol_bit = 0;
  // Reset values and tally saturation limit
  localparam logic [7:0] flags_reset = 8'h00;
  localparam logic [7:0] count_reset = 8'h00;
  localparam logic [7:0] config_reset = 8'h00;
  localparam logic [1:0] threshold_reset = 2'h0;
  localparam logic [7:0] tally_max = 8'hff;
  // Narrowing modes
  typedef enum logic [1:0]
  {
    raw10_normal = 2'h0,
    raw10_reserved = 2'h1,
    raw10_upper8 = 2'h2,
    raw10_lower8 = 2'h3
  } narrowing_t;
endpackage
`default_nettype wire
